// ### common/vdac_map.svh
`ifndef VDAC_MAP_SVH
`define VDAC_MAP_SVH
`define VDAC_ADDR_HIGH 12'h000
`define VDAC_ADDR_LOW 12'h004
`define VDAC_ADDR_CTRL 12'h008
`define VDAC_ADDR_STATUS 12'h00c
`define VDAC_RST_BYTE 8'h00
`define VDAC_EN_POS 0
`define VDAC_SETTLE_NS 1000
`define VDAC_CLK_NS 40
`endif

// ### common/vdac_pkg.sv
package vdac_pkg;
  typedef logic [7:0] vdac_byte_type;
  typedef logic [15:0] vdac_code_type;
  typedef enum logic [1:0] {
    VDAC_OFF = 2'b00,
    VDAC_SETTLING = 2'b01,
    VDAC_READY = 2'b10
  } vdac_state_type;
endpackage

// ### verilog/vdac_top.sv
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "vdac_map.svh"
module vdac_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output vdac_pkg::vdac_code_type DAC_CODE,
  output logic DAC_LOAD,
  output logic DAC_POWER_DOWN,
  output logic DAC_SETTLED
);
  import vdac_pkg::*;

  localparam int SETTLE_CYC = (`VDAC_SETTLE_NS + `VDAC_CLK_NS - 1) /
    `VDAC_CLK_NS;
  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);

  // Data group
  vdac_byte_type high_q;
  vdac_byte_type high_d;
  vdac_byte_type low_q;
  vdac_byte_type low_d;
  vdac_byte_type shadow_q;
  vdac_byte_type shadow_d;
  logic load_q;
  logic load_d;

  // Control group
  logic en_q;
  logic en_d;
  logic pd_q;
  logic pd_d;

  // Settle group
  vdac_state_type state_q;
  vdac_state_type state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic settled;

  // Read group
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Bus decode
  logic wr;
  logic hit;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `VDAC_ADDR_HIGH) || (a == `VDAC_ADDR_LOW) ||
      (a == `VDAC_ADDR_CTRL) || (a == `VDAC_ADDR_STATUS);
  endfunction

  // Write strobe aimed at one register offset
  function automatic logic wr_at(
    input logic strobe,
    input logic [11:0] a,
    input logic [11:0] off);
    wr_at = strobe && (a == off);
  endfunction

  // Reserved bits and unmapped offsets read as zero
  function automatic logic [31:0] read_mux(
    input logic [11:0] a,
    input vdac_byte_type hi,
    input vdac_byte_type lo,
    input logic en,
    input logic ready);
    logic [31:0] r;
    r = 32'h00000000;
    case (a)
      `VDAC_ADDR_HIGH: r = {24'h000000, hi};
      // Applied byte, never the pending shadow
      `VDAC_ADDR_LOW: r = {24'h000000, lo};
      `VDAC_ADDR_CTRL: r = {31'h00000000, en};
      `VDAC_ADDR_STATUS: r = {30'h00000000, ready, en};
      default: r = 32'h00000000;
    endcase
    read_mux = r;
  endfunction

  // Zero wait states: every access completes in its first access cycle
  assign PREADY = 1'b1;
  assign hit = mapped(PADDR);
  assign wr = PSEL && PENABLE && PWRITE;
  assign settled = (state_q == VDAC_READY);
  assign PSLVERR = PSEL && PENABLE && !hit;
  assign PRDATA = rdata_q;

  // Data group: shadow, both code bytes and the load strobe
  always_comb begin
    high_d = high_q;
    low_d = low_q;
    shadow_d = shadow_q;
    load_d = 1'b0;
    if (wr_at(wr, PADDR, `VDAC_ADDR_LOW)) begin
      shadow_d = PWDATA[7:0];
    end
    // Both bytes land on one edge so the code never tears
    if (wr_at(wr, PADDR, `VDAC_ADDR_HIGH)) begin
      high_d = PWDATA[7:0];
      low_d = shadow_q;
      load_d = 1'b1;
    end
  end

  // Control group: enable bit and the power-down level
  always_comb begin
    en_d = en_q;
    if (wr_at(wr, PADDR, `VDAC_ADDR_CTRL)) begin
      en_d = PWDATA[`VDAC_EN_POS];
    end
    pd_d = !en_d;
  end

  // Read data is prepared in setup so it is valid during access
  always_comb begin
    rdata_d = rdata_q;
    if (PSEL && !PENABLE && !PWRITE) begin
      rdata_d = read_mux(PADDR, high_q, low_q, en_q, settled);
    end
  end

  // Settle tracking is informative; it never blocks a load
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      VDAC_OFF: begin
        if (en_q) begin
          state_d = VDAC_SETTLING;
          cnt_d = 8'h00;
        end
      end
      VDAC_SETTLING: begin
        if (!en_q) begin
          state_d = VDAC_OFF;
        end else if (cnt_q == SETTLE_LAST) begin
          state_d = VDAC_READY;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      VDAC_READY: begin
        if (!en_q) begin
          state_d = VDAC_OFF;
        end
      end
      default: state_d = VDAC_OFF;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      high_q <= `VDAC_RST_BYTE;
      low_q <= `VDAC_RST_BYTE;
      shadow_q <= `VDAC_RST_BYTE;
      load_q <= 1'b0;
    end else begin
      high_q <= high_d;
      low_q <= low_d;
      shadow_q <= shadow_d;
      load_q <= load_d;
    end
  end

  // Power-down follows the enable bit on the same edge
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      en_q <= 1'b0;
      pd_q <= 1'b1;
    end else begin
      en_q <= en_d;
      pd_q <= pd_d;
    end
  end

  // Counter holds when enable drops and restarts from zero when enable is set again
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= VDAC_OFF;
      cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign DAC_CODE = {high_q, low_q};
  assign DAC_LOAD = load_q;
  assign DAC_POWER_DOWN = pd_q;
  assign DAC_SETTLED = settled;

endmodule

// ### testbench/vdac_chk.sv
`timescale 1ns/1ps
`include "vdac_map.svh"
module vdac_chk (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic DAC_LOAD,
  input wire logic DAC_POWER_DOWN,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire vdac_pkg::vdac_code_type DAC_CODE
);
  import vdac_pkg::*;
  wire wr = PSEL && PENABLE && PWRITE;
  wire rd = PSEL && PENABLE && !PWRITE;
  wire hi = wr && PADDR == `VDAC_ADDR_HIGH;
  wire lo = wr && PADDR == `VDAC_ADDR_LOW;
  wire en = wr && PADDR == `VDAC_ADDR_CTRL;
  logic [7:0] sh_q;
  // Mirrors the hidden shadow so the copy can be judged
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) sh_q <= 8'h00;
    else if (lo) sh_q <= PWDATA[7:0];
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  chk_low_shadow: assert property (lo |=>
    !DAC_LOAD && $stable(DAC_CODE)) else $error("low write moved code");
  chk_high_load: assert property (hi |=> DAC_LOAD &&
    DAC_CODE[15:8] == $past(PWDATA[7:0])) else $error("bad high load");
  chk_low_copy: assert property (hi |=>
    DAC_CODE[7:0] == $past(sh_q)) else $error("shadow not copied");
  chk_load_cause: assert property (DAC_LOAD |-> $past(hi))
    else $error("stray load");
  chk_pd_on: assert property (en && PWDATA[0] |->
    ##[1:2] !DAC_POWER_DOWN) else $error("not enabled");
  chk_pd_off: assert property (en && !PWDATA[0] |->
    ##[1:2] DAC_POWER_DOWN) else $error("not powered down");
  chk_ctrl_rsvd: assert property (rd && PADDR == `VDAC_ADDR_CTRL |->
    PRDATA[31:1] == 0) else $error("reserved bits set");
  chk_low_read: assert property (rd && PADDR == `VDAC_ADDR_LOW |->
    PRDATA[7:0] == DAC_CODE[7:0]) else $error("low read wrong");
endmodule
bind vdac_top vdac_chk u_chk (.*);

// ### testbench/vdac_tb_top.sv
`timescale 1ns/1ps
`include "vdac_map.svh"
module vdac_tb_top;
  logic CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic PREADY, PSLVERR, DAC_LOAD, DAC_POWER_DOWN, DAC_SETTLED;
  vdac_pkg::vdac_code_type DAC_CODE;
  int err_total = 0, num_checks = 0;
  logic err_seen = 0;
  vdac_top u_dut (.*);
  initial forever #20 CLK = ~CLK;
  task cmp(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("errors %0d checks %0d", err_total, num_checks);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, e);
    int n;
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n == 50) begin
      err_total++;
      complete_run;
    end
    err_seen = PSLVERR;
    if (!w) cmp(PRDATA, e);
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    RESET <= 0;
    xfer(0, `VDAC_ADDR_HIGH, 0, 0);
    cmp(32'(err_seen), 0);
    xfer(0, `VDAC_ADDR_STATUS, 0, 0);
    xfer(0, `VDAC_ADDR_CTRL, 0, 0);
    cmp(32'(DAC_POWER_DOWN), 1);
    xfer(1, `VDAC_ADDR_CTRL, 32'hff, 0);
    xfer(0, `VDAC_ADDR_CTRL, 0, 1);
    cmp(32'(DAC_POWER_DOWN), 0);
    repeat (25) @(posedge CLK);
    xfer(0, `VDAC_ADDR_STATUS, 0, 32'h3);
    cmp(32'(DAC_SETTLED), 1);
    xfer(1, `VDAC_ADDR_LOW, 32'h34, 0);
    xfer(0, `VDAC_ADDR_LOW, 0, 0);
    cmp(32'(DAC_CODE), 0);
    xfer(1, `VDAC_ADDR_HIGH, 32'h12, 0);
    xfer(0, `VDAC_ADDR_LOW, 0, 32'h34);
    cmp(32'(DAC_CODE), 32'h1234);
    xfer(1, `VDAC_ADDR_HIGH, 32'h156, 0);
    xfer(0, `VDAC_ADDR_HIGH, 0, 32'h56);
    cmp(32'(DAC_CODE), 32'h5634);
    xfer(1, `VDAC_ADDR_CTRL, 0, 0);
    xfer(0, 12'h010, 0, 0);
    cmp(32'(err_seen), 1);
    cmp(32'(DAC_POWER_DOWN), 1);
    cmp(32'(DAC_SETTLED), 0);
    complete_run;
  end
endmodule
